// [fct_pkg.sv]
/*
  Constants, register map and carrier types for the five channel
  capture and compare timer. Assumes a 32-bit APB master and a single
  125 MHz core clock.
*/
`default_nettype none
package fct_pkg;
  // Channel count and width of a count.
  localparam int FCT_NCH = 5;
  localparam int FCT_NGR = 10;
  localparam int FCT_CW = 16;

  // Global register byte offsets.
  localparam logic [7:0] FCT_OFS_START = 8'h00;
  localparam logic [7:0] FCT_OFS_SYNC = 8'h04;
  localparam logic [7:0] FCT_OFS_MODE = 8'h08;
  localparam logic [7:0] FCT_OFS_FLAGS = 8'h0C;
  localparam logic [7:0] FCT_OFS_DMAEN = 8'h10;
  localparam logic [7:0] FCT_OFS_DEAD = 8'h14;
  // Channel blocks start at 0x20 and take 0x20 bytes each.
  localparam logic [2:0] FCT_CH_FIRST = 3'h1;
  localparam logic [2:0] FCT_CH_LAST = 3'h5;
  localparam logic [4:0] FCT_CH_CTRL = 5'h00;
  localparam logic [4:0] FCT_CH_CNT = 5'h04;
  localparam logic [4:0] FCT_CH_GRA = 5'h08;
  localparam logic [4:0] FCT_CH_GRB = 5'h0C;
  localparam logic [4:0] FCT_CH_BRA = 5'h10;
  localparam logic [4:0] FCT_CH_BRB = 5'h14;

  // Mode register field positions.
  localparam int FCT_MODE_PWM_LSB = 0;
  localparam int FCT_MODE_SIX_LSB = 8;
  localparam int FCT_MODE_PC_BIT = 10;
  localparam int FCT_MODE_BUF_LSB = 11;
  // Channel control field positions.
  localparam int FCT_CTRL_CLK_LSB = 0;
  localparam int FCT_CTRL_CLR_LSB = 4;
  localparam int FCT_CTRL_IOA_LSB = 8;
  localparam int FCT_CTRL_IOB_LSB = 12;
  // Capture mode bit inside a 4-bit io field.
  localparam int FCT_IO_CAP_BIT = 3;

  // Reset value of every control register.
  localparam logic [31:0] FCT_RST_VAL = 32'h0000_0000;

  // Counter clock sources.
  typedef enum logic [2:0] {
    FCT_CLK_SYS = 3'b000,
    FCT_CLK_DIV2 = 3'b001,
    FCT_CLK_DIV4 = 3'b010,
    FCT_CLK_DIV8 = 3'b011,
    FCT_CLK_EXT = 3'b100
  } fct_clk_e;

  // Counter clear sources.
  typedef enum logic [1:0] {
    FCT_CLR_NONE = 2'b00,
    FCT_CLR_A = 2'b01,
    FCT_CLR_B = 2'b10
  } fct_clr_e;

  // Six phase motor modes.
  typedef enum logic [1:0] {
    FCT_SIX_OFF = 2'b00,
    FCT_SIX_RSYNC = 2'b01,
    FCT_SIX_COMPL = 2'b10
  } fct_six_e;

  // Compare actions (io field, capture bit low).
  localparam logic [1:0] FCT_OC_LOW = 2'b01;
  localparam logic [1:0] FCT_OC_HIGH = 2'b10;
  localparam logic [1:0] FCT_OC_TOGGLE = 2'b11;
  // Capture edges (io field, capture bit high).
  localparam logic [1:0] FCT_IC_RISE = 2'b00;
  localparam logic [1:0] FCT_IC_FALL = 2'b01;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fct_apb_req_s;

  // One counter channel.
  typedef struct packed {
    logic [2:0] clk_sel;
    logic [1:0] clr_sel;
    logic [3:0] io_a;
    logic [3:0] io_b;
    logic [15:0] cnt;
    logic [15:0] first_general_reg;
    logic [15:0] second_general_reg;
  } fct_chan_s;

  // Whole state of the timer.
  typedef struct packed {
    logic [4:0] start;
    logic [4:0] sync;
    logic [4:0] pwm;
    logic [1:0] six;
    logic pc_en;
    logic [1:0] buf_en;
    logic [9:0] flags;
    logic [9:0] dma_en;
    logic [7:0] dead;
    fct_chan_s [4:0] ch;
    logic [1:0][1:0][15:0] capture_buffer_reg;
    logic [2:0] pre;
    logic [4:0] eclk_s1;
    logic [4:0] eclk_s2;
    logic [4:0] eclk_p;
    logic [9:0] pin_s1;
    logic [9:0] pin_s2;
    logic [9:0] pin_p;
    logic [1:0] qd_s1;
    logic [1:0] qd_s2;
    logic [1:0] qd_p;
    logic [9:0] pin_out;
    logic [9:0] pin_oe;
    logic [9:0] evt;
    logic [9:0] dma_req;
    logic [5:0] phase;
    logic [2:0][7:0] dtc;
    logic [2:0] raw_p;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fct_state_s;
endpackage : fct_pkg
`default_nettype wire

// [fct_timer.sv]
/*
  Five channel 16-bit capture and compare timer with APB registers,
  standard and six phase PWM, buffered capture and quadrature counting.
  Assumes an APB master on CORE_CLK_I; all pins are asynchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - Five 16-bit counters, each clocked by sys clock, /2, /4, /8 or external pin.
// - Ten general registers, each set to act as compare or capture.
// - Four extra 16-bit buffer registers belong to the general registers.
// - Count equal to a compare register drives a chosen level and/or request.
// - A match can set, clear, toggle its pin, request, clear counter, trigger DMA.
// - Every channel can make pulses one counter clock long.
// - A chosen pin edge (rise, fall, both) copies the count into the register.
// - A capture can also clear the channel counter.
// - Channels 3 and 4 push the older capture into a buffer register.
// - A capture event can raise a DMA transfer request.
// - Synchronised counters are written together and cleared together.
// - Synchronised channels keep capture and compare events on the common count.
// - PWM mode drives pin high on first match, low on second match.
// - PWM period is set by clearing on the first or second register.
// - Complementary and reset synchronised six phase PWM, dead time only in the first.
// - Phase counting makes channel 2 count up or down from two quadrature inputs.
// - In phase counting the channel 2 compares still raise requests.
module fct_timer (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // APB slave.
  input wire fct_pkg::fct_apb_req_s APB_REQ_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Timer pins.
  input wire logic [4:0] EXT_CLK_I,
  input wire logic [9:0] TIOC_I,
  output logic [9:0] TIOC_O,
  output logic [9:0] TIOC_OE_O,
  input wire logic QUAD_A_I,
  input wire logic QUAD_B_I,
  output logic [5:0] PHASE_O,
  // Event requests towards interrupt and DMA controllers.
  output logic [9:0] EVENT_O,
  output logic [9:0] DMA_REQ_O
);
  fct_pkg::fct_state_s st_q;
  fct_pkg::fct_state_s st_d;

  // Per channel working signals.
  logic [4:0] tick;
  logic [4:0] clr_own;
  logic [4:0] clr_all;
  logic [9:0] match;
  logic [9:0] cap;
  logic [9:0] rise;
  logic [9:0] fall;
  logic [4:0] eclk_rise;
  logic q_da;
  logic q_db;
  logic q_step;
  logic q_up;
  logic [15:0] rdv;
  logic rd_err;
  logic wr_en;
  logic rd_en;
  logic [2:0] ach;
  logic [15:0] duty [3];
  logic [2:0] raw;

  // Next state of the whole timer.
  always_comb begin
    st_d = st_q;
    tick = '0;
    clr_own = '0;
    clr_all = '0;
    match = '0;
    cap = '0;
    rdv = '0;
    rd_err = 1'b0;
    ach = 3'(APB_REQ_I.paddr[7:5] - fct_pkg::FCT_CH_FIRST);
    wr_en = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite;
    rd_en = APB_REQ_I.psel & ~APB_REQ_I.penable & ~APB_REQ_I.pwrite;

    // Pin synchronisers; the first stage feeds only the second.
    st_d.eclk_s1 = EXT_CLK_I;
    st_d.eclk_s2 = st_q.eclk_s1;
    st_d.eclk_p = st_q.eclk_s2;
    st_d.pin_s1 = TIOC_I;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_p = st_q.pin_s2;
    st_d.qd_s1 = {QUAD_B_I, QUAD_A_I};
    st_d.qd_s2 = st_q.qd_s1;
    st_d.qd_p = st_q.qd_s2;
    eclk_rise = st_q.eclk_s2 & ~st_q.eclk_p;
    rise = st_q.pin_s2 & ~st_q.pin_p;
    fall = ~st_q.pin_s2 & st_q.pin_p;

    // Quadrature step: one phase changed, direction from the other phase.
    q_da = st_q.qd_s2[0] ^ st_q.qd_p[0];
    q_db = st_q.qd_s2[1] ^ st_q.qd_p[1];
    q_step = st_q.pc_en & (q_da ^ q_db);
    q_up = q_da ? (st_q.qd_s2[0] != st_q.qd_s2[1]) : (st_q.qd_s2[1] == st_q.qd_s2[0]);

    // Prescaler for the divided counter clocks.
    st_d.pre = 3'(st_q.pre + 3'h1);

    // Ticks, matches and captures for every channel.
    for (int c = 0; c < fct_pkg::FCT_NCH; c++) begin
      case (st_q.ch[c].clk_sel)
        fct_pkg::FCT_CLK_SYS: tick[c] = 1'b1;
        fct_pkg::FCT_CLK_DIV2: tick[c] = st_q.pre[0];
        fct_pkg::FCT_CLK_DIV4: tick[c] = &st_q.pre[1:0];
        fct_pkg::FCT_CLK_DIV8: tick[c] = &st_q.pre;
        fct_pkg::FCT_CLK_EXT: tick[c] = eclk_rise[c];
        default: tick[c] = 1'b0;
      endcase
      if (c == 2 && st_q.pc_en) begin
        tick[c] = q_step;
      end
      tick[c] = tick[c] & st_q.start[c];
      // Compares see the count on the tick; sync channels share the count.
      if (!st_q.ch[c].io_a[fct_pkg::FCT_IO_CAP_BIT] || st_q.pwm[c]) begin
        match[2*c] = tick[c] & (st_q.ch[c].cnt == st_q.ch[c].first_general_reg);
      end
      if (!st_q.ch[c].io_b[fct_pkg::FCT_IO_CAP_BIT] || st_q.pwm[c]) begin
        match[2*c+1] = tick[c] & (st_q.ch[c].cnt == st_q.ch[c].second_general_reg);
      end
      for (int g = 0; g < 2; g++) begin
        logic [3:0] io;
        io = (g == 0) ? st_q.ch[c].io_a : st_q.ch[c].io_b;
        if (io[fct_pkg::FCT_IO_CAP_BIT] && !st_q.pwm[c]) begin
          case (io[1:0])
            fct_pkg::FCT_IC_RISE: cap[2*c+g] = rise[2*c+g];
            fct_pkg::FCT_IC_FALL: cap[2*c+g] = fall[2*c+g];
            default: cap[2*c+g] = rise[2*c+g] | fall[2*c+g];
          endcase
        end
      end
      clr_own[c] = ((st_q.ch[c].clr_sel == fct_pkg::FCT_CLR_A) & (match[2*c] | cap[2*c]))
          | ((st_q.ch[c].clr_sel == fct_pkg::FCT_CLR_B) & (match[2*c+1] | cap[2*c+1]));
    end

    // Any clear in the sync group clears every member.
    for (int c = 0; c < fct_pkg::FCT_NCH; c++) begin
      clr_all[c] = clr_own[c] | (st_q.sync[c] & |(clr_own & st_q.sync));
    end

    // Counters, captures and pin actions.
    for (int c = 0; c < fct_pkg::FCT_NCH; c++) begin
      if (clr_all[c]) begin
        st_d.ch[c].cnt = '0;
      end else if (tick[c]) begin
        if (c == 2 && st_q.pc_en && !q_up) begin
          st_d.ch[c].cnt = 16'(st_q.ch[c].cnt - 16'h0001);
        end else begin
          st_d.ch[c].cnt = 16'(st_q.ch[c].cnt + 16'h0001);
        end
      end
      if (cap[2*c]) begin
        st_d.ch[c].first_general_reg = st_q.ch[c].cnt;
      end
      if (cap[2*c+1]) begin
        st_d.ch[c].second_general_reg = st_q.ch[c].cnt;
      end
      if (c >= 3 && st_q.buf_en[c-3]) begin
        if (cap[2*c]) begin
          st_d.capture_buffer_reg[c-3][0] = st_q.ch[c].first_general_reg;
        end
        if (cap[2*c+1]) begin
          st_d.capture_buffer_reg[c-3][1] = st_q.ch[c].second_general_reg;
        end
      end
      if (st_q.pwm[c]) begin
        // Pin A rises on the first register and falls on the second.
        st_d.pin_oe[2*c] = 1'b1;
        st_d.pin_oe[2*c+1] = 1'b0;
        if (match[2*c+1]) begin
          st_d.pin_out[2*c] = 1'b0;
        end else if (match[2*c]) begin
          st_d.pin_out[2*c] = 1'b1;
        end
      end else begin
        for (int g = 0; g < 2; g++) begin
          logic [3:0] io;
          io = (g == 0) ? st_q.ch[c].io_a : st_q.ch[c].io_b;
          st_d.pin_oe[2*c+g] = ~io[fct_pkg::FCT_IO_CAP_BIT] & (|io[1:0]);
          // Output changes on the tick itself, so a pulse can be one tick wide.
          if (match[2*c+g]) begin
            case (io[1:0])
              fct_pkg::FCT_OC_LOW: st_d.pin_out[2*c+g] = 1'b0;
              fct_pkg::FCT_OC_HIGH: st_d.pin_out[2*c+g] = 1'b1;
              fct_pkg::FCT_OC_TOGGLE: st_d.pin_out[2*c+g] = ~st_q.pin_out[2*c+g];
              default: st_d.pin_out[2*c+g] = st_q.pin_out[2*c+g];
            endcase
          end
        end
      end
    end

    // Event pulses, DMA requests and sticky flags.
    st_d.evt = match | cap;
    st_d.dma_req = (match | cap) & st_q.dma_en;

    // Six phase outputs from the channel 3 count against three duties.
    duty[0] = st_q.ch[3].second_general_reg;
    duty[1] = st_q.ch[4].first_general_reg;
    duty[2] = st_q.ch[4].second_general_reg;
    for (int k = 0; k < 3; k++) begin
      raw[k] = st_q.ch[3].cnt < duty[k];
      st_d.raw_p[k] = raw[k];
      if (st_q.six == fct_pkg::FCT_SIX_RSYNC) begin
        st_d.phase[2*k] = raw[k];
        st_d.phase[2*k+1] = ~raw[k];
        st_d.dtc[k] = '0;
      end else if (st_q.six == fct_pkg::FCT_SIX_COMPL) begin
        // A change holds both legs low for the dead time.
        if (raw[k] != st_q.raw_p[k]) begin
          st_d.dtc[k] = st_q.dead;
        end else if (st_q.dtc[k] != 8'h00) begin
          st_d.dtc[k] = 8'(st_q.dtc[k] - 8'h01);
        end
        st_d.phase[2*k] = raw[k] & (st_d.dtc[k] == 8'h00);
        st_d.phase[2*k+1] = ~raw[k] & (st_d.dtc[k] == 8'h00);
      end else begin
        st_d.phase[2*k] = 1'b0;
        st_d.phase[2*k+1] = 1'b0;
        st_d.dtc[k] = '0;
      end
    end

    // Read path: decoded in the setup phase, presented in the access phase.
    if (APB_REQ_I.paddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_START) begin
      rdv = {11'h000, st_q.start};
    end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_SYNC) begin
      rdv = {11'h000, st_q.sync};
    end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_MODE) begin
      rdv = {3'h0, st_q.buf_en, st_q.pc_en, st_q.six, 3'h0, st_q.pwm};
    end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_FLAGS) begin
      rdv = {6'h00, st_q.flags};
    end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_DMAEN) begin
      rdv = {6'h00, st_q.dma_en};
    end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_DEAD) begin
      rdv = {8'h00, st_q.dead};
    end else if (APB_REQ_I.paddr[7:5] < fct_pkg::FCT_CH_FIRST
        || APB_REQ_I.paddr[7:5] > fct_pkg::FCT_CH_LAST) begin
      rd_err = 1'b1;
    end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_CTRL) begin
      rdv = {st_q.ch[ach].io_b, st_q.ch[ach].io_a, 2'h0, st_q.ch[ach].clr_sel, 1'b0,
          st_q.ch[ach].clk_sel};
    end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_CNT) begin
      rdv = st_q.ch[ach].cnt;
    end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_GRA) begin
      rdv = st_q.ch[ach].first_general_reg;
    end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_GRB) begin
      rdv = st_q.ch[ach].second_general_reg;
    end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_BRA && ach >= 3'h3) begin
      rdv = st_q.capture_buffer_reg[1'(ach - 3'h3)][0];
    end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_BRB && ach >= 3'h3) begin
      rdv = st_q.capture_buffer_reg[1'(ach - 3'h3)][1];
    end else begin
      rd_err = 1'b1;
    end
    st_d.pready = 1'b1;
    if (APB_REQ_I.psel && !APB_REQ_I.penable) begin
      st_d.prdata = rd_en ? {16'h0000, rdv} : 32'h0000_0000;
      st_d.pslverr = rd_err;
    end

    // Write path: the bus wins over hardware for counters and general registers.
    if (wr_en && !st_q.pslverr) begin
      if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_START) begin
        st_d.start = APB_REQ_I.pwdata[4:0];
      end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_SYNC) begin
        st_d.sync = APB_REQ_I.pwdata[4:0];
      end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_MODE) begin
        st_d.pwm = APB_REQ_I.pwdata[fct_pkg::FCT_MODE_PWM_LSB +: 5];
        st_d.six = APB_REQ_I.pwdata[fct_pkg::FCT_MODE_SIX_LSB +: 2];
        st_d.pc_en = APB_REQ_I.pwdata[fct_pkg::FCT_MODE_PC_BIT];
        st_d.buf_en = APB_REQ_I.pwdata[fct_pkg::FCT_MODE_BUF_LSB +: 2];
      end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_FLAGS) begin
        st_d.flags = st_q.flags & ~APB_REQ_I.pwdata[9:0];
      end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_DMAEN) begin
        st_d.dma_en = APB_REQ_I.pwdata[9:0];
      end else if (APB_REQ_I.paddr == fct_pkg::FCT_OFS_DEAD) begin
        st_d.dead = APB_REQ_I.pwdata[7:0];
      end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_CTRL) begin
        st_d.ch[ach].clk_sel = APB_REQ_I.pwdata[fct_pkg::FCT_CTRL_CLK_LSB +: 3];
        st_d.ch[ach].clr_sel = APB_REQ_I.pwdata[fct_pkg::FCT_CTRL_CLR_LSB +: 2];
        st_d.ch[ach].io_a = APB_REQ_I.pwdata[fct_pkg::FCT_CTRL_IOA_LSB +: 4];
        st_d.ch[ach].io_b = APB_REQ_I.pwdata[fct_pkg::FCT_CTRL_IOB_LSB +: 4];
      end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_CNT) begin
        for (int c = 0; c < fct_pkg::FCT_NCH; c++) begin
          if (3'(c) == ach || (st_q.sync[c] && st_q.sync[ach])) begin
            st_d.ch[c].cnt = APB_REQ_I.pwdata[15:0];
          end
        end
      end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_GRA) begin
        st_d.ch[ach].first_general_reg = APB_REQ_I.pwdata[15:0];
      end else if (APB_REQ_I.paddr[4:0] == fct_pkg::FCT_CH_GRB) begin
        st_d.ch[ach].second_general_reg = APB_REQ_I.pwdata[15:0];
      end
    end
    // Set beats clear on the same cycle.
    st_d.flags = st_d.flags | match | cap;
  end

  // State register.
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_q <= fct_pkg::fct_state_s'(fct_pkg::FCT_RST_VAL);
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register.
  assign PRDATA_O = st_q.prdata;
  assign PREADY_O = st_q.pready;
  assign PSLVERR_O = st_q.pslverr;
  assign TIOC_O = st_q.pin_out;
  assign TIOC_OE_O = st_q.pin_oe;
  assign PHASE_O = st_q.phase;
  assign EVENT_O = st_q.evt;
  assign DMA_REQ_O = st_q.dma_req;
endmodule : fct_timer
`default_nettype wire

// [fct_timer_props.sv]
/*
  Concurrent checks on the ports of the capture and compare timer.
  Assumes a bind onto fct_timer with one clock and active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fct_timer_props (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // Watched ports.
  input wire fct_pkg::fct_apb_req_s APB_REQ_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [9:0] TIOC_O,
  input wire logic [5:0] PHASE_O,
  input wire logic [9:0] EVENT_O,
  input wire logic [9:0] DMA_REQ_O
);
  logic acc;
  // Marks the access phase of a bus transfer.
  assign acc = APB_REQ_I.psel & APB_REQ_I.penable;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  // Bus answers and outputs around reset.
  chk_ready_held: assert property ($past(RSTN_I) |-> PREADY_O)
    else $error("ready low outside reset");
  chk_reset_quiet: assert property (!$past(RSTN_I) |->
    EVENT_O == 10'h000 && DMA_REQ_O == 10'h000 && TIOC_O == 10'h000 && PHASE_O == 6'h00)
    else $error("output active right after reset");
  chk_upper_zero: assert property (PRDATA_O[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_misalign_err: assert property (acc && APB_REQ_I.paddr[1:0] != 2'h0 |-> PSLVERR_O)
    else $error("misaligned access not refused");
  chk_err_rdata: assert property (acc && !APB_REQ_I.pwrite && PSLVERR_O |-> PRDATA_O == 32'h0)
    else $error("refused read returned data");
  chk_start_ok: assert property (acc && APB_REQ_I.paddr == fct_pkg::FCT_OFS_START |-> !PSLVERR_O)
    else $error("mapped address refused");
  // Event side effects and motor legs.
  chk_dma_evt: assert property ((DMA_REQ_O & ~EVENT_O) == 10'h000)
    else $error("dma request without event");
  chk_legs_excl: assert property (((PHASE_O[0] & PHASE_O[1]) | (PHASE_O[2] & PHASE_O[3]) |
    (PHASE_O[4] & PHASE_O[5])) == 1'b0)
    else $error("both legs of one phase high");
endmodule : fct_timer_props
`default_nettype wire

// [fct_pin_model.sv]
/*
  Model of the sources outside the timer: capture pins, count clocks
  and a quadrature encoder. Assumes the bench requests levels and steps.
*/
`timescale 1ns/1ps
`default_nettype none
module fct_pin_model (
  // Clock.
  input wire logic clk_i,
  // Requests from the bench.
  input wire logic [9:0] cap_i,
  input wire logic [4:0] ext_i,
  input wire logic step_i,
  input wire logic up_i,
  // Pins towards the timer.
  output logic [9:0] tioc_o,
  output logic [4:0] ext_clk_o,
  output logic quad_a_o,
  output logic quad_b_o
);
  logic [1:0] pos_q = 2'h0;
  logic [9:0] cap_q = 10'h000;
  logic [4:0] ext_q = 5'h00;
  // Pins lag the request by one cycle, as a real source would.
  always @(posedge clk_i) begin
    cap_q <= cap_i;
    ext_q <= ext_i;
    if (step_i) begin
      pos_q <= up_i ? pos_q + 2'h1 : pos_q - 2'h1;
    end
  end
  // Gray sequence, so only one phase moves per step.
  assign quad_a_o = pos_q[0] ^ pos_q[1];
  assign quad_b_o = pos_q[1];
  assign tioc_o = cap_q;
  assign ext_clk_o = ext_q;
endmodule : fct_pin_model
`default_nettype wire

// [test_five_channel_capture_compare_timer.sv]
/*
  Self-checking bench for the capture and compare timer.
  Assumes fct_pkg, fct_timer, fct_timer_props and fct_pin_model.
*/
`timescale 1ns/1ps
`default_nettype none
bind fct_timer fct_timer_props fct_timer_props_i (
  .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .APB_REQ_I(APB_REQ_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TIOC_O(TIOC_O), .PHASE_O(PHASE_O),
  .EVENT_O(EVENT_O), .DMA_REQ_O(DMA_REQ_O));
module test_five_channel_capture_compare_timer;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  fct_pkg::fct_apb_req_s req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] tioc_in;
  logic [9:0] tioc_out;
  logic [9:0] tioc_oe;
  logic [4:0] ext_clk;
  logic qa;
  logic qb;
  logic [9:0] evt;
  logic [9:0] dma;
  logic [5:0] phase;
  int t;
  logic [9:0] cap = 10'h000;
  logic [4:0] ext = 5'h00;
  logic step = 1'b0;
  logic up = 1'b0;
  logic [31:0] rdat;
  logic rerr;
  logic [15:0] g;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  // Device and pin sources.
  fct_timer fct_timer_i (.CORE_CLK_I(core_clk), .RSTN_I(rst_n), .APB_REQ_I(req),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_CLK_I(ext_clk),
    .TIOC_I(tioc_in), .TIOC_O(tioc_out), .TIOC_OE_O(tioc_oe), .QUAD_A_I(qa),
    .QUAD_B_I(qb), .PHASE_O(phase), .EVENT_O(evt), .DMA_REQ_O(dma));
  fct_pin_model fct_pin_model_i (.clk_i(core_clk), .cap_i(cap), .ext_i(ext),
    .step_i(step), .up_i(up), .tioc_o(tioc_in), .ext_clk_o(ext_clk), .quad_a_o(qa),
    .quad_b_o(qb));
  // Free running core clock.
  always #4 core_clk = ~core_clk;
  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize;
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    req <= '0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  task automatic wev(input int i);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (evt[i] !== 1'b1 && n < 300);
    chk(32'(n < 300), 32'h1);
  endtask : wev
  task automatic qstep(input logic u);
    step <= 1'b1;
    up <= u;
    @(posedge core_clk);
    step <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : qstep
  // Main sequence of register tests.
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(8'h08, 32'h0);
    rd(8'hA0, 32'h0);
    apb(1'b0, 8'h02, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b0, 8'hFC, 32'h0);
    chk(rdat, 32'h0);
    wr(8'h04, 32'h3);
    wr(8'h24, 32'h1234);
    rd(8'h44, 32'h1234);
    wr(8'h04, 32'h0);
    wr(8'h24, 32'h0);
    wr(8'h28, 32'h5);
    wr(8'h2C, 32'hA);
    wr(8'h20, 32'h20);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1);
    wev(0);
    chk(32'(tioc_out[0]), 32'h1);
    chk(32'(tioc_oe[0]), 32'h1);
    wev(1);
    chk(32'(tioc_out[0]), 32'h0);
    wr(8'h00, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk(32'(rdat <= 32'hA), 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rdat & 32'h3, 32'h3);
    wr(8'h0C, 32'h3);
    rd(8'h0C, 32'h0);
    wr(8'h08, 32'h800);
    wr(8'h80, 32'hA10);
    wr(8'h10, 32'h40);
    wr(8'h00, 32'h8);
    cap <= 10'h040;
    repeat (7) @(posedge core_clk);
    cap <= 10'h000;
    repeat (13) @(posedge core_clk);
    cap <= 10'h040;
    wev(6);
    chk(32'(dma[6]), 32'h1);
    apb(1'b0, 8'h88, 32'h0);
    g = rdat[15:0];
    chk(rdat, 32'hC);
    apb(1'b0, 8'h90, 32'h0);
    g = g - rdat[15:0];
    chk(32'(g), 32'h6);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h400);
    wr(8'h68, 32'h3);
    wr(8'h60, 32'h200);
    wr(8'h00, 32'h4);
    for (int i = 0; i < 8; i++) qstep(i < 6);
    rd(8'h64, 32'h4);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rdat & 32'h50, 32'h50);
    wr(8'hA0, 32'h4);
    wr(8'h00, 32'h10);
    repeat (5) begin
      ext <= 5'h10;
      repeat (3) @(posedge core_clk);
      ext <= 5'h00;
      repeat (3) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    rd(8'hA4, 32'h5);
    // Channel 4 toggles on the first register at half rate and clears on it.
    wr(8'h00, 32'h0);
    wr(8'hA4, 32'h0);
    wr(8'hA8, 32'h2);
    wr(8'hA0, 32'h311);
    wr(8'h00, 32'h10);
    wev(8);
    t = cyc;
    chk(32'(tioc_out[8]), 32'h1);
    chk(32'(tioc_oe[8]), 32'h1);
    wev(8);
    chk(32'(tioc_out[8]), 32'h0);
    chk(32'(cyc - t), 32'h6);
    // Six phase legs from a frozen channel 3 count, then dead time.
    wr(8'h00, 32'h0);
    wr(8'h84, 32'h10);
    wr(8'h8C, 32'h20);
    wr(8'hA8, 32'h8);
    wr(8'hAC, 32'h10);
    wr(8'h08, 32'h100);
    @(posedge core_clk);
    chk(32'(phase), 32'h29);
    wr(8'h14, 32'h4);
    wr(8'h08, 32'h200);
    wr(8'h84, 32'h4);
    @(posedge core_clk);
    chk(32'(phase), 32'h01);
    repeat (3) @(posedge core_clk);
    chk(32'(phase), 32'h01);
    @(posedge core_clk);
    chk(32'(phase), 32'h15);
    summarize();
  end
endmodule : test_five_channel_capture_compare_timer
`default_nettype wire
